/* File: logic/rtcrt_core.sv */
// rtc register transfer core: i2c slave, transfer registers, bcd clock counters
// assumes scl_in and sda_in already synchronous to clk, osc_tick one pulse per 32.768 khz period
//
// Function
// - sixteen byte registers, clock via transfer copies
// - bcd 24-hour calendar with month length rollover
// - control registers stored as plain binary
// - pointer advances after every data byte
// - idle bus refreshes transfer copies all together
// - bus start freezes transfer copies
// - refresh resumes at control address or stop
// - counters keep running while copies frozen
// - write bits taken on scl rise, byte stored
// - clock writes copied on reaching 08h or stop
// - clock write commit clears divider and subsecond
// - subsecond register only ever loads zero
// - hundredths tick is oscillator divided by 328
// - subsecond holds bcd tenths and hundredths
// - seconds bit7 halts oscillator, seconds bcd 0-59
// - minutes bit7 enables failure interrupt
// - hours bcd 0 to 23, no am/pm
// - weekday upper nibble selects wave rate
// - weekday low bits cycle 1 to 7
// - date bcd in bits 5 to 0
// - century code in month bits 7 to 6
// - month bcd 1 to 12 in bits 4 to 0
// - year bcd 0 to 99 full byte
`timescale 1ns/100ps
`include "rtcrt_regs.svh"

module rtcrt_core
    import rtcrt_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary value
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic osc_tick,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic oscillator_halt,
    output logic osc_failure_irq_enable,
    output logic [3:0] wave_rate_select
);

    rtcrt_state_t s_reg;
    rtcrt_state_t s_next;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic hund_tick;
    logic commit;
    logic ptr_moved;
    logic [7:0] byte_in;
    logic [7:0] rd_byte;

    // bcd increment of a byte, caller handles the wrap
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // leap year from bcd year and century code
    function automatic logic is_leap(input logic [7:0] y, input logic [1:0] cb);
        logic div4;
        if (y[4]) begin
            div4 = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end else begin
            div4 = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end
        is_leap = div4 && !((y == 8'h00) && (cb != 2'h0));
    endfunction

    // last bcd day of the month
    function automatic logic [5:0] last_day(input logic [4:0] m, input logic [7:0] y, input logic [1:0] cb);
        case (m)
            5'h02: last_day = is_leap(y, cb) ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
            default: last_day = 6'h31;
        endcase
    endfunction

    // one hundredth of a second forward through the whole calendar
    function automatic rtcrt_bank_t advance(input rtcrt_bank_t c);
        rtcrt_bank_t r;
        logic [1:0] cen;
        r = c;
        cen = c[6][7:6];
        if (c[0] != `RTCRT_SUB_LAST) begin
            r[0] = bcd_inc(c[0]);
        end else begin
            r[0] = 8'h00;
            // control bits in bit 7 ride along, tens never reach it
            if (c[1][6:0] != `RTCRT_SM_LAST) begin
                r[1] = bcd_inc(c[1]);
            end else begin
                r[1] = {c[1][7], 7'h00};
                if (c[2][6:0] != `RTCRT_SM_LAST) begin
                    r[2] = bcd_inc(c[2]);
                end else begin
                    r[2] = {c[2][7], 7'h00};
                    if (c[3][5:0] != `RTCRT_HOUR_LAST) begin
                        r[3] = bcd_inc(c[3]);
                    end else begin
                        r[3] = 8'h00;
                        if (c[4][2:0] == `RTCRT_WDAY_LAST) begin
                            r[4] = {c[4][7:4], 1'b0, `RTCRT_WDAY_FIRST};
                        end else begin
                            r[4] = {c[4][7:4], 1'b0, c[4][2:0] + 3'h1};
                        end
                        if (c[5][5:0] < last_day(c[6][4:0], c[7], cen)) begin
                            r[5] = bcd_inc(c[5]);
                        end else begin
                            r[5] = 8'h01;
                            if (c[6][4:0] != `RTCRT_MONTH_LAST) begin
                                r[6] = bcd_inc(c[6]);
                            end else begin
                                if (c[7] == `RTCRT_YEAR_LAST) begin
                                    r[7] = 8'h00;
                                    cen = c[6][7:6] + 2'h1;
                                end else begin
                                    r[7] = bcd_inc(c[7]);
                                end
                                r[6] = {cen, 6'h01};
                            end
                        end
                    end
                end
            end
        end
        advance = r;
    endfunction

    // bus events from the synchronous pin samples
    assign scl_rise = scl_in && !s_reg.scl_q;
    assign scl_fall = !scl_in && s_reg.scl_q;
    assign start_c = scl_in && s_reg.scl_q && s_reg.sda_q && !sda_in;
    assign stop_c = scl_in && s_reg.scl_q && !s_reg.sda_q && sda_in;
    assign byte_in = {s_reg.shreg[6:0], sda_in};
    // oscillator stop gates the divider
    assign hund_tick = osc_tick && !s_reg.cnt[1][`RTCRT_OSC_HALT_BIT] && (s_reg.div == `RTCRT_DIV_LAST);
    // reads see the frozen copy in the clock section, the register itself above
    assign rd_byte = s_reg.ptr[`RTCRT_CTRL_SECTION_BIT] ? s_reg.ctrl[s_reg.ptr[2:0]] : s_reg.xfer[s_reg.ptr[2:0]];

    // next state: serial interface, pointer, commit, timekeeping, refresh
    always_comb begin
        s_next = s_reg;
        commit = 1'b0;
        ptr_moved = 1'b0;
        s_next.scl_q = scl_in;
        s_next.sda_q = sda_in;
        case (s_reg.phase)
            RT_IDLE: begin
            end
            RT_ADDR: begin
                if (scl_rise) begin
                    s_next.shreg = byte_in;
                    s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                end else if (scl_fall && s_reg.bit_cnt == 4'h8) begin
                    if (s_reg.shreg[7:1] == DEV_ADDR) begin
                        s_next.phase = RT_AACK;
                        s_next.sda_oe = 1'b1;
                        s_next.rd_mode = s_reg.shreg[0];
                    end else begin
                        // not for us: pending clock writes keep the copy frozen
                        s_next.phase = RT_IDLE;
                        s_next.frozen = s_reg.dirty;
                    end
                end
            end
            RT_AACK: begin
                if (scl_fall) begin
                    s_next.bit_cnt = 4'h0;
                    if (s_reg.rd_mode) begin
                        s_next.phase = RT_RDATA;
                        s_next.shreg = rd_byte;
                        s_next.sda_oe = !rd_byte[7];
                    end else begin
                        s_next.phase = RT_WDATA;
                        s_next.sda_oe = 1'b0;
                        s_next.ptr_loaded = 1'b0;
                    end
                end
            end
            RT_WDATA: begin
                if (scl_rise) begin
                    s_next.shreg = byte_in;
                    s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                    if (s_reg.bit_cnt == 4'h7) begin
                        ptr_moved = 1'b1;
                        s_next.ptr_loaded = 1'b1;
                        if (!s_reg.ptr_loaded) begin
                            s_next.ptr = byte_in[3:0];
                        end else begin
                            if (s_reg.ptr[`RTCRT_CTRL_SECTION_BIT]) begin
                                s_next.ctrl[s_reg.ptr[2:0]] = byte_in;
                            end else begin
                                // held in the copy until commit; subsecond only takes zero
                                s_next.xfer[s_reg.ptr[2:0]] = (s_reg.ptr == `RTCRT_SUBSECOND_COUNT) ? 8'h00 : byte_in;
                                s_next.dirty = 1'b1;
                            end
                            s_next.ptr = s_reg.ptr + 4'h1;
                        end
                    end
                end else if (scl_fall && s_reg.bit_cnt == 4'h8) begin
                    s_next.phase = RT_WACK;
                    s_next.sda_oe = 1'b1;
                end
            end
            RT_WACK: begin
                if (scl_fall) begin
                    s_next.phase = RT_WDATA;
                    s_next.sda_oe = 1'b0;
                    s_next.bit_cnt = 4'h0;
                end
            end
            RT_RDATA: begin
                if (scl_rise) begin
                    s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                end else if (scl_fall) begin
                    if (s_reg.bit_cnt == 4'h8) begin
                        s_next.phase = RT_RACK;
                        s_next.sda_oe = 1'b0;
                        s_next.ptr = s_reg.ptr + 4'h1;
                        ptr_moved = 1'b1;
                    end else begin
                        s_next.shreg = {s_reg.shreg[6:0], 1'b0};
                        s_next.sda_oe = !s_reg.shreg[6];
                    end
                end
            end
            RT_RACK: begin
                if (scl_rise) begin
                    s_next.acked = !sda_in;
                end else if (scl_fall) begin
                    if (s_reg.acked) begin
                        s_next.phase = RT_RDATA;
                        s_next.bit_cnt = 4'h0;
                        s_next.shreg = rd_byte;
                        s_next.sda_oe = !rd_byte[7];
                    end else begin
                        // master said no more: wait for stop or start
                        s_next.phase = RT_IDLE;
                    end
                end
            end
            default: begin
                s_next.phase = RT_IDLE;
                s_next.sda_oe = 1'b0;
            end
        endcase
        // pointer into control section releases the copy and commits writes
        if (ptr_moved) begin
            if (s_next.ptr[`RTCRT_CTRL_SECTION_BIT]) begin
                s_next.frozen = 1'b0;
                commit = s_next.dirty;
            end else begin
                s_next.frozen = 1'b1;
            end
        end
        // stop ends the transaction and the freeze
        if (stop_c) begin
            s_next.phase = RT_IDLE;
            s_next.sda_oe = 1'b0;
            s_next.frozen = 1'b0;
            commit = s_next.dirty;
        end
        // start (also repeated) freezes the copy for one consistent instant
        if (start_c) begin
            s_next.phase = RT_ADDR;
            s_next.bit_cnt = 4'h0;
            s_next.sda_oe = 1'b0;
            s_next.frozen = 1'b1;
        end
        // commit restarts the clock from the written copy
        if (commit) begin
            s_next.cnt = s_next.xfer;
            s_next.cnt[0] = 8'h00;
            s_next.div = 9'h000;
            s_next.dirty = 1'b0;
        end else if (osc_tick && !s_reg.cnt[1][`RTCRT_OSC_HALT_BIT]) begin
            // counters run regardless of the freeze
            s_next.div = hund_tick ? 9'h000 : s_reg.div + 9'h001;
            if (hund_tick) begin
                s_next.cnt = advance(s_reg.cnt);
            end
        end
        // all counters copied at one instant while the bus is quiet
        if (!s_next.frozen) begin
            s_next.xfer = s_next.cnt;
        end
    end

    // state register, synchronous reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_reg <= '0;
            s_reg.phase <= RT_IDLE;
            s_reg.scl_q <= 1'b1;
            s_reg.sda_q <= 1'b1;
            s_reg.cnt <= {`RTCRT_RST_YEAR, `RTCRT_RST_MONTH, `RTCRT_RST_DATE, `RTCRT_RST_WEEKDAY,
                          `RTCRT_RST_HOURS, `RTCRT_RST_MINUTES, `RTCRT_RST_SECONDS, `RTCRT_RST_SUBSECOND};
            s_reg.xfer <= {`RTCRT_RST_YEAR, `RTCRT_RST_MONTH, `RTCRT_RST_DATE, `RTCRT_RST_WEEKDAY,
                           `RTCRT_RST_HOURS, `RTCRT_RST_MINUTES, `RTCRT_RST_SECONDS, `RTCRT_RST_SUBSECOND};
            s_reg.ctrl <= {`RTCRT_RST_STATUS, `RTCRT_RST_MATCH, `RTCRT_RST_MATCH, `RTCRT_RST_MATCH,
                           `RTCRT_RST_MATCH, `RTCRT_RST_MONTH_MATCH, `RTCRT_RST_TIMEOUT, `RTCRT_RST_RATE_TRIM};
        end else begin
            s_reg <= s_next;
        end
    end

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = s_reg.sda_oe;
    assign oscillator_halt = s_reg.cnt[1][`RTCRT_OSC_HALT_BIT];
    assign osc_failure_irq_enable = s_reg.cnt[2][`RTCRT_FAIL_IRQ_BIT];
    assign wave_rate_select = s_reg.cnt[4][7:4];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_start_freeze: assert property (start_c |=> s_reg.frozen && s_reg.phase == RT_ADDR)
        else $error("start did not freeze transfer copy");
    chk_stop_release: assert property (stop_c && !start_c |=> !s_reg.frozen && s_reg.phase == RT_IDLE)
        else $error("stop did not release transfer copy");
    chk_refresh_copy: assert property (!s_reg.frozen |-> s_reg.xfer == s_reg.cnt)
        else $error("transfer copy not refreshed while idle");
    chk_ptr_step: assert property (s_reg.phase == RT_WDATA && scl_rise && s_reg.bit_cnt == 4'h7
        && s_reg.ptr_loaded && !start_c && !stop_c |=> s_reg.ptr == $past(s_reg.ptr) + 4'h1)
        else $error("pointer did not advance after data byte");
    chk_commit_clear: assert property (commit |=> s_reg.cnt[0] == 8'h00 && s_reg.div == 9'h000 && !s_reg.dirty)
        else $error("commit left divider or subsecond running");
    chk_sub_zero: assert property (s_reg.phase == RT_WDATA && scl_rise && s_reg.bit_cnt == 4'h7
        && s_reg.ptr_loaded && s_reg.ptr == 4'h0 && !stop_c |=> s_reg.xfer[0] == 8'h00)
        else $error("subsecond took a nonzero value");
    chk_run_frozen: assert property (s_reg.frozen && hund_tick && !commit |=> s_reg.cnt[0] != $past(s_reg.cnt[0]))
        else $error("counters stopped while frozen");
    chk_div_wrap: assert property (hund_tick && !commit |=> s_reg.div == 9'h000 ##1 s_reg.div <= 9'h001)
        else $error("divider did not wrap at 328");
    chk_day_wrap: assert property (hund_tick && !commit && s_reg.cnt[0] == 8'h99 && s_reg.cnt[1][6:0] == 7'h59
        && s_reg.cnt[2][6:0] == 7'h59 && s_reg.cnt[3] == 8'h23 |=> s_reg.cnt[3] == 8'h00 && s_reg.cnt[1][6:0] == 7'h00)
        else $error("hours did not wrap after 23");

endmodule

/* File: logic/rtcrt_regs.svh */
// register offsets, reset values and divider counts of the rtc register transfer core
// assumes inclusion by bare name from package and design files
`ifndef RTCRT_REGS_SVH
`define RTCRT_REGS_SVH

// register offsets, clock section 0 to 7 and control section 8 to f
`define RTCRT_SUBSECOND_COUNT 4'h0
`define RTCRT_SECONDS_AND_OSC_STOP 4'h1
`define RTCRT_MINUTES_AND_FAIL_IRQ 4'h2
`define RTCRT_HOURS_COUNT 4'h3
`define RTCRT_WEEKDAY_AND_WAVE_SELECT 4'h4
`define RTCRT_DATE_COUNT 4'h5
`define RTCRT_MONTH_AND_CENTURY 4'h6
`define RTCRT_YEAR_COUNT 4'h7
`define RTCRT_RATE_TRIM 4'h8
`define RTCRT_TIMEOUT_CONFIG 4'h9
`define RTCRT_MONTH_MATCH_CTRL 4'ha
`define RTCRT_DATE_MATCH 4'hb
`define RTCRT_HOUR_MATCH 4'hc
`define RTCRT_MINUTE_MATCH 4'hd
`define RTCRT_SECOND_MATCH 4'he
`define RTCRT_EVENT_STATUS 4'hf

// field positions
`define RTCRT_OSC_HALT_BIT 7
`define RTCRT_FAIL_IRQ_BIT 7
`define RTCRT_CTRL_SECTION_BIT 3

// reset values, clock section
`define RTCRT_RST_SUBSECOND 8'h00
`define RTCRT_RST_SECONDS 8'h00
`define RTCRT_RST_MINUTES 8'h00
`define RTCRT_RST_HOURS 8'h00
`define RTCRT_RST_WEEKDAY 8'h11
`define RTCRT_RST_DATE 8'h01
`define RTCRT_RST_MONTH 8'h01
`define RTCRT_RST_YEAR 8'h00
// reset values, control section
`define RTCRT_RST_RATE_TRIM 8'h80
`define RTCRT_RST_TIMEOUT 8'h00
`define RTCRT_RST_MONTH_MATCH 8'h40
`define RTCRT_RST_MATCH 8'h00
`define RTCRT_RST_STATUS 8'h04

// oscillator divider: 32.768 khz ticks divided by 328 give hundredths
`define RTCRT_DIV_RATIO 9'd328
`define RTCRT_DIV_LAST 9'd327

// bcd limits
`define RTCRT_SUB_LAST 8'h99
`define RTCRT_SM_LAST 7'h59
`define RTCRT_HOUR_LAST 6'h23
`define RTCRT_WDAY_LAST 3'h7
`define RTCRT_WDAY_FIRST 3'h1
`define RTCRT_MONTH_LAST 5'h12
`define RTCRT_YEAR_LAST 8'h99

`endif

/* File: logic/rtcrt_pkg.sv */
// types of the rtc register transfer core
// assumes nothing beyond the register header
package rtcrt_pkg;

    // serial interface phases
    typedef enum logic [2:0] {
        RT_IDLE,
        RT_ADDR,
        RT_AACK,
        RT_WDATA,
        RT_WACK,
        RT_RDATA,
        RT_RACK
    } rtcrt_phase_t;

    typedef logic [7:0][7:0] rtcrt_bank_t;

    // whole state of the core
    typedef struct packed {
        rtcrt_phase_t phase;
        logic scl_q;
        logic sda_q;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [3:0] ptr;
        logic ptr_loaded;
        logic rd_mode;
        logic acked;
        logic frozen;
        logic dirty;
        logic sda_oe;
        logic [8:0] div;
        rtcrt_bank_t cnt;
        rtcrt_bank_t xfer;
        rtcrt_bank_t ctrl;
    } rtcrt_state_t;

endpackage

/* File: sim/rtcrt_i2c_master.sv */
// i2c bus master model driving the serial pins of the rtc core
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/100ps

module rtcrt_i2c_master (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull,
    output logic res_valid,
    output logic [7:0] res_val
);
    int half = 3; // clk cycles per scl phase, larger means a slower master
    logic r;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        res_valid = 1'b0;
        res_val = 8'h00;
    end

    // result strobe one cycle wide, so the bench monitor sees each byte once
    always @(posedge clk) begin
        if (res_valid) begin
            res_valid <= 1'b0;
        end
    end

    task automatic hold();
        repeat (half) @(posedge clk);
    endtask

    // sda moves one edge after scl falls, never while scl is high
    task automatic clk_bit(input logic b);
        @(posedge clk) sda_pull <= !b;
        hold();
        scl <= 1'b1;
        hold();
        @(negedge clk) r = sda_line;
        @(posedge clk) scl <= 1'b0;
    endtask

    // works from idle and as a repeated start from scl low
    task automatic bus_start();
        @(posedge clk) sda_pull <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        sda_pull <= 1'b1;
        hold();
        scl <= 1'b0;
    endtask

    // leaves the wire released, so the pull-up takes it high
    task automatic bus_stop();
        @(posedge clk) sda_pull <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        sda_pull <= 1'b0;
        hold();
    endtask

    task automatic report(input logic [7:0] v);
        res_val <= v;
        res_valid <= 1'b1;
    endtask

    // msb first, ninth clock samples the acknowledge
    task automatic wr_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) clk_bit(b[i]);
        clk_bit(1'b1);
        report({7'h00, !r});
    endtask

    // last byte is refused with a nack before the stop
    task automatic rd_byte(input logic last);
        logic [7:0] d;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1);
            d[i] = r;
        end
        clk_bit(last);
        report(d);
    endtask
endmodule

/* File: sim/rtcrt_tb.sv */
// self-checking bench of the rtc register transfer core through its serial pins
// assumes the i2c master model is compiled before this file
`timescale 1ns/100ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
$display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end

module testbench;
    localparam logic [6:0] ADDR = 7'h2a; // arbitrary bus address, same as the core default
    localparam int SEC_TICKS = 32800; // 100 hundredths of 328 ticks each
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic osc_tick = 1'b0;
    logic scl, m_pull, sda_in, sda_oe, sda_o, halt, irq_en, res_valid;
    logic [3:0] wave;
    logic [7:0] res_val, exp_b, r;
    logic [7:0] exp_q[$];
    logic [7:0] vals[$];
    logic [7:0] masks[8] = '{8'hbf, 8'hff, 8'hdf, 8'hff, 8'hbf, 8'hff, 8'hff, 8'hc4};
    int mismatches = 0;
    int samples_checked = 0;

    always #5 clk = ~clk;
    // open-drain wire with pull-up, low while either party pulls; core drives its output level when enabled
    assign sda_in = !(m_pull || (sda_oe && !sda_o));

    rtcrt_core #(.DEV_ADDR(ADDR)) dut_u (
        .clk(clk), .resetn(resetn), .osc_tick(osc_tick), .scl_in(scl), .sda_in(sda_in),
        .sda_out(sda_o), .sda_oe(sda_oe), .oscillator_halt(halt), .osc_failure_irq_enable(irq_en),
        .wave_rate_select(wave)
    );
    rtcrt_i2c_master m (
        .clk(clk), .sda_line(sda_in), .scl(scl), .sda_pull(m_pull), .res_valid(res_valid),
        .res_val(res_val)
    );

    task automatic send(input logic [7:0] b, input logic ack);
        exp_q.push_back({7'h00, ack});
        m.wr_byte(b);
    endtask

    task automatic point(input logic [3:0] p);
        m.bus_start();
        send({ADDR, 1'b0}, 1'b1);
        send({4'h0, p}, 1'b1);
    endtask

    task automatic wr(input logic [3:0] p, input logic [7:0] d[$]);
        point(p);
        foreach (d[i]) send(d[i], 1'b1);
        m.bus_stop();
    endtask

    // read after a repeated start, all bytes noted in order
    task automatic rd_cont(input logic [7:0] e[$]);
        m.bus_start();
        send({ADDR, 1'b1}, 1'b1);
        foreach (e[i]) begin
            exp_q.push_back(e[i]);
            m.rd_byte(i == e.size() - 1);
        end
        m.bus_stop();
    endtask

    task automatic rd(input logic [3:0] p, input logic [7:0] e[$]);
        point(p);
        rd_cont(e);
    endtask

    // one oscillator period is a pulse followed by a quiet cycle
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk) osc_tick <= 1'b1;
            @(posedge clk) osc_tick <= 1'b0;
        end
    endtask

    task automatic final_report();
        // a note still queued means a byte never came back
        if (exp_q.size() != 0) begin
            mismatches++;
            $display("[FAIL] %0t %0d expected bytes never arrived", $time, exp_q.size());
        end
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // every byte or acknowledge from the master is matched to the oldest note
    always @(posedge clk) begin
        if (res_valid) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("[FAIL] %0t byte arrived with nothing expected", $time);
            end else begin
                exp_b = exp_q.pop_front();
                `CHK(res_val, exp_b)
            end
        end
    end

    // about 77k cycles of work expected, limit kept under 100k
    initial begin
        repeat (95000) @(posedge clk);
        mismatches++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        r = 8'($urandom(32'h1f83));
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        `CHK(wave, 4'h1)
        // reset values of both sections, then wrap back to offset 0
        rd(4'h0, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h01, 8'h01, 8'h00, 8'h80, 8'h00, 8'h40,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00});
        // wrong device address gets no acknowledge
        m.bus_start();
        send({ADDR ^ 7'h01, 1'b0}, 1'b0);
        m.bus_stop();
        m.half = 3 + $urandom_range(2);
        // control section is plain storage, fixed-zero bits kept clear
        for (int i = 0; i < 8; i++) vals.push_back(8'($urandom) & masks[i]);
        wr(4'h8, vals);
        rd(4'h8, vals);
        // nonzero subsecond refused, last second of a non-leap century february
        r = 8'($urandom) & 8'hbf;
        wr(4'h0, '{8'h55, 8'h59, 8'hd9, 8'h23, 8'h37, 8'h28, 8'h42, 8'h00, r});
        @(negedge clk);
        `CHK(irq_en, 1'b1)
        `CHK(wave, 4'h3)
        `CHK(halt, 1'b0)
        rd(4'h8, '{r});
        // frozen copy during an access while the counters keep running
        ticks(327);
        point(4'h0);
        ticks(1);
        rd_cont('{8'h00, 8'h59});
        rd(4'h0, '{8'h01});
        ticks(SEC_TICKS - 328);
        rd(4'h0, '{8'h00, 8'h00, 8'h80, 8'h00, 8'h31, 8'h01, 8'h43, 8'h00});
        // halt bit only reaches the counters at the stop
        point(4'h1);
        send(8'h80, 1'b1);
        @(negedge clk);
        `CHK(halt, 1'b0)
        m.bus_stop();
        @(negedge clk);
        `CHK(halt, 1'b1)
        // nonzero subsecond write reads back as zero from the copy before any commit
        point(4'h0);
        send(8'h55, 1'b1);
        rd(4'h0, '{8'h00});
        ticks(400);
        rd(4'h0, '{8'h00, 8'h80});
        // pointer stepping from 07 to 08 commits before any stop
        point(4'h4);
        foreach (vals[i]) vals[i] = 8'h00;
        send(8'h51, 1'b1);
        send(8'h01, 1'b1);
        send(8'h01, 1'b1);
        send(8'h25, 1'b1);
        send(r, 1'b1);
        @(negedge clk);
        `CHK(wave, 4'h5)
        m.bus_stop();
        rd(4'h4, '{8'h51, 8'h01, 8'h01, 8'h25, r});
        // second reset in mid-run
        @(posedge clk) resetn <= 1'b0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        `CHK(halt, 1'b0)
        `CHK(wave, 4'h1)
        rd(4'h1, '{8'h00});
        final_report();
    end
endmodule
